// File: rtl/output_clamp_lin_polarity.sv
// Output clamp and linearizer polarity control of the sensor signal path.
// Assumes a pipelined linearizer outside that answers each fed sample once,
// and a register port whose strobes are one cycle long.
//
// Behaviour
// - Output never above the upper clamp level.
// - Upper code zero highest; all ones mid-scale.
// - Upper level: full minus half-scale times code/64.
// - Output never below the lower clamp level.
// - Lower code zero lowest; all ones mid-scale.
// - Lower level: zero plus half-scale times code/64.
// - Input inversion before linearizer, only when table complete.
// - Output inversion after linearizer, only when table complete.
// - Linearizer bypassed unless table complete flag set.
`include "clamp_lin_regs.svh"
`default_nettype none

module output_clamp_lin_polarity
    import clamp_lin_pkg::*;
(
    input  wire logic      sys_clk_i,
    input  wire logic      reset_n_i,
    input  wire reg_addr_t reg_addr_i,
    input  wire reg_word_t reg_wdata_i,
    input  wire logic      reg_wr_i,
    input  wire logic      reg_rd_i,
    output reg_word_t      reg_rdata_o,
    input  wire sample_t   sample_i,
    input  wire logic      sample_valid_i,
    output sample_t        lin_feed_o,
    output logic           lin_feed_valid_o,
    input  wire sample_t   lin_result_i,
    input  wire logic      lin_result_valid_i,
    output out_code_t      out_code_o,
    output logic           out_valid_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic        table_done_reg;
    logic        pre_invert_reg;
    logic        post_invert_reg;
    logic [8:0]  customer_tag_reg;
    limit_code_t upper_code_reg;
    limit_code_t lower_code_reg;
    logic        ratiometric_disable_reg;
    reg_word_t   rdata_reg;
    reg_word_t   rdata_next;
    sample_t     stage1_reg;
    logic        stage1_valid_reg;
    sample_t     pre_value;
    sample_t     lin_select;
    logic        lin_select_valid;
    sample_t     post_value;
    out_code_t   clamp_code;
    out_code_t   out_code_reg;
    logic        out_valid_reg;

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Polarity word: table flag, inversions and the stored tag
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            table_done_reg   <= `DONE_RESET;
            post_invert_reg  <= `INV_RESET;
            pre_invert_reg   <= `INV_RESET;
            customer_tag_reg <= `TAG_RESET;
        end else if (reg_wr_i && reg_addr_i == `ADDR_POLARITY_WORD) begin
            table_done_reg   <= reg_wdata_i[`TABLE_DONE_BIT];
            post_invert_reg  <= reg_wdata_i[`POST_INV_BIT];
            pre_invert_reg   <= reg_wdata_i[`PRE_INV_BIT];
            customer_tag_reg <= reg_wdata_i[`TAG_MSB:`TAG_LSB];
        end
    end

    // Limit word: zero codes give the widest window when unprogrammed
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upper_code_reg <= `UPPER_RESET;
            lower_code_reg <= `LOWER_RESET;
        end else if (reg_wr_i && reg_addr_i == `ADDR_LIMIT_WORD) begin
            upper_code_reg <= reg_wdata_i[`UPPER_MSB:`UPPER_LSB];
            lower_code_reg <= reg_wdata_i[`LOWER_MSB:`LOWER_LSB];
        end
    end

    // Ratiometry mode; codes are supply-relative, so the mapping is the same
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ratiometric_disable_reg <= `RATIO_DIS_RESET;
        end else if (reg_wr_i && reg_addr_i == `ADDR_MODE_WORD) begin
            ratiometric_disable_reg <= reg_wdata_i[`RATIO_DIS_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    // Unmapped offsets and unused bits read as zero
    always_comb begin
        rdata_next = '0;
        unique case (reg_addr_i)
            `ADDR_POLARITY_WORD: begin
                rdata_next[`TABLE_DONE_BIT]    = table_done_reg;
                rdata_next[`POST_INV_BIT]      = post_invert_reg;
                rdata_next[`PRE_INV_BIT]       = pre_invert_reg;
                rdata_next[`TAG_MSB:`TAG_LSB]  = customer_tag_reg;
            end
            `ADDR_LIMIT_WORD: begin
                rdata_next[`UPPER_MSB:`UPPER_LSB] = upper_code_reg;
                rdata_next[`LOWER_MSB:`LOWER_LSB] = lower_code_reg;
            end
            `ADDR_MODE_WORD: begin
                rdata_next[`RATIO_DIS_BIT] = ratiometric_disable_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------------------
    // Stage 1: input polarity ahead of the linearizer
    // ------------------------------------------------------------------------
    polarity_stage u_pre_polarity (
        .value_i  (sample_i),
        .invert_i (pre_invert_reg),
        .enable_i (table_done_reg),
        .value_o  (pre_value)
    );

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1_reg       <= '0;
            stage1_valid_reg <= 1'b0;
        end else begin
            stage1_reg       <= pre_value;
            stage1_valid_reg <= sample_valid_i;
        end
    end

    // Linearizer is only fed while its table is marked complete
    assign lin_feed_o       = stage1_reg;
    assign lin_feed_valid_o = stage1_valid_reg && table_done_reg;

    // ------------------------------------------------------------------------
    // Stage 2: path select, output polarity, clamp
    // ------------------------------------------------------------------------
    // Stray linearizer answers are dropped while bypassed
    always_comb begin
        if (table_done_reg) begin
            lin_select       = lin_result_i;
            lin_select_valid = lin_result_valid_i;
        end else begin
            lin_select       = stage1_reg;
            lin_select_valid = stage1_valid_reg;
        end
    end

    polarity_stage u_post_polarity (
        .value_i  (lin_select),
        .invert_i (post_invert_reg),
        .enable_i (table_done_reg),
        .value_o  (post_value)
    );

    // Clamping last so inversion cannot push past a limit
    limit_saturate u_limit (
        .value_i      (post_value),
        .upper_code_i (upper_code_reg),
        .lower_code_i (lower_code_reg),
        .code_o       (clamp_code)
    );

    // Output code holds between samples
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_code_reg  <= `ZERO_SCALE_CODE;
            out_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= lin_select_valid;
            if (lin_select_valid) begin
                out_code_reg <= clamp_code;
            end
        end
    end

    assign out_code_o  = out_code_reg;
    assign out_valid_o = out_valid_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Limits seen by the sample in flight
    out_code_t hi_seen;
    out_code_t lo_seen;
    assign hi_seen = upper_limit(upper_code_reg);
    assign lo_seen = lower_limit(lower_code_reg);

    sequence bypass_sample_s;
        sample_valid_i && !table_done_reg ##1 !table_done_reg;
    endsequence

    sequence table_sample_s;
        sample_valid_i && table_done_reg ##1 table_done_reg;
    endsequence

    sequence table_answer_s;
        table_done_reg && lin_result_valid_i;
    endsequence

    upper_never_exceeded_a: assert property (
        out_valid_o |-> out_code_o <= $past(hi_seen))
        else $error("output above upper clamp");

    upper_code_ends_a: assert property (
        lin_select_valid && upper_code_reg == 6'h00 && to_code(post_value) == 12'hfff
        |=> out_code_o == 12'hfff)
        else $error("upper code zero clipped full scale");

    upper_code_top_a: assert property (
        lin_select_valid && upper_code_reg == 6'h3f && to_code(post_value) > 12'h81f
        |=> out_code_o == 12'h81f)
        else $error("upper code all ones wrong level");

    lower_never_under_a: assert property (
        out_valid_o |-> out_code_o >= $past(lo_seen))
        else $error("output below lower clamp");

    lower_code_top_a: assert property (
        lin_select_valid && lower_code_reg == 6'h3f && to_code(post_value) < 12'h7e0
        |=> out_code_o == 12'h7e0)
        else $error("lower code all ones wrong level");

    lower_step_size_a: assert property (
        lin_select_valid && lower_code_reg == 6'h01 && to_code(post_value) == 12'h000
        |=> out_code_o == 12'h020)
        else $error("lower limit step not 32 codes");

    pre_invert_gate_a: assert property (
        sample_valid_i |=> lin_feed_o ==
            (($past(table_done_reg) && $past(pre_invert_reg)) ? negate_sat($past(sample_i)) : $past(sample_i)))
        else $error("input inversion wrong");

    post_invert_gate_a: assert property (
        table_done_reg && lin_result_valid_i && post_invert_reg && lin_result_i == 12'sh000
        && upper_code_reg == 6'h00 && lower_code_reg == 6'h00
        |=> out_valid_o && out_code_o == 12'h800)
        else $error("output inversion path wrong");

    bypass_latency_a: assert property (
        bypass_sample_s |=> out_valid_o && !lin_feed_valid_o)
        else $error("bypass path latency wrong");

    table_path_feed_a: assert property (
        table_sample_s |-> lin_feed_valid_o)
        else $error("table path not fed");

    stray_answer_drop_a: assert property (
        !table_done_reg && lin_result_valid_i && !stage1_valid_reg |=> !out_valid_o)
        else $error("bypassed linearizer answer used");

    clamp_after_invert_a: assert property (
        table_done_reg && lin_result_valid_i && post_invert_reg && lin_result_i == 12'sh800
        && upper_code_reg == 6'h3f |=> out_code_o == 12'h81f)
        else $error("clamp not after output inversion");

    // Stored limit fields and the upper field's readback
    upper_field_write_a: assert property (
        reg_wr_i && reg_addr_i == `ADDR_LIMIT_WORD
        |=> upper_code_reg == $past(reg_wdata_i[`UPPER_MSB:`UPPER_LSB]))
        else $error("upper limit code not stored");

    lower_field_write_a: assert property (
        reg_wr_i && reg_addr_i == `ADDR_LIMIT_WORD
        |=> lower_code_reg == $past(reg_wdata_i[`LOWER_MSB:`LOWER_LSB]))
        else $error("lower limit code not stored");

    limit_read_back_a: assert property (
        reg_rd_i && reg_addr_i == `ADDR_LIMIT_WORD
        |=> reg_rdata_o[`UPPER_MSB:`UPPER_LSB] == $past(upper_code_reg))
        else $error("upper limit code read back wrong");

    // Scale ends land exactly on the coded level
    upper_step_level_a: assert property (
        lin_select_valid && to_code(post_value) == 12'hfff
        |=> out_code_o == 12'(4095 - 32 * $past(upper_code_reg)))
        else $error("upper level not 32 codes per step");

    lower_code_zero_a: assert property (
        lin_select_valid && lower_code_reg == 6'h00 && to_code(post_value) == 12'h000
        |=> out_code_o == 12'h000)
        else $error("lower code zero clipped zero scale");

    lower_step_level_a: assert property (
        lin_select_valid && to_code(post_value) == 12'h000
        |=> out_code_o == 12'(32 * $past(lower_code_reg)))
        else $error("lower level not 32 codes per step");

    // Bypassed path keeps the stored inversions out
    pre_bypass_plain_a: assert property (
        sample_valid_i && !table_done_reg |=> lin_feed_o == $past(sample_i))
        else $error("input inverted while bypassed");

    post_bypass_plain_a: assert property (
        !table_done_reg && stage1_valid_reg && upper_code_reg == 6'h00 && lower_code_reg == 6'h00
        |=> out_code_o == to_code($past(stage1_reg)))
        else $error("output inverted while bypassed");

    bypass_no_feed_a: assert property (
        !table_done_reg |-> !lin_feed_valid_o)
        else $error("linearizer fed while bypassed");

    table_answer_out_a: assert property (
        table_answer_s |=> out_valid_o)
        else $error("linearizer answer not passed on");

    // A held code only moves with a valid pulse
    code_hold_idle_a: assert property (
        !out_valid_o |-> $stable(out_code_o))
        else $error("output code moved without valid");

endmodule

`default_nettype wire

// File: rtl/clamp_lin_regs.svh
// Register offsets, field positions, reset values and counts for the
// output clamp and linearizer polarity block.
// Assumes inclusion by bare name from the package and the main module.
`ifndef CLAMP_LIN_REGS_SVH
`define CLAMP_LIN_REGS_SVH

// ----------------------------------------------------------------------------
// Word offsets on the register port
// ----------------------------------------------------------------------------
`define ADDR_POLARITY_WORD 8'h1b
`define ADDR_LIMIT_WORD    8'h1c
`define ADDR_MODE_WORD     8'h1e

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TABLE_DONE_BIT 23
`define POST_INV_BIT   22
`define PRE_INV_BIT    21
`define TAG_MSB        20
`define TAG_LSB        12
`define UPPER_MSB      23
`define UPPER_LSB      18
`define LOWER_MSB      17
`define LOWER_LSB      12
`define RATIO_DIS_BIT  0

// ----------------------------------------------------------------------------
// Reset values (unprogrammed fields)
// ----------------------------------------------------------------------------
`define TAG_RESET       9'h000
`define UPPER_RESET     6'h00
`define LOWER_RESET     6'h00
`define INV_RESET       1'b0
`define DONE_RESET      1'b0
`define RATIO_DIS_RESET 1'b0

// ----------------------------------------------------------------------------
// Output scale and timing counts
// ----------------------------------------------------------------------------
`define FULL_SCALE_CODE 12'hfff
`define ZERO_SCALE_CODE 12'h000
`define BYPASS_LATENCY  2

`endif

// File: rtl/clamp_lin_pkg.sv
// Types and shared decode functions of the clamp and polarity path.
// Assumes the register header sits beside it in rtl/.
`include "clamp_lin_regs.svh"
`default_nettype none

package clamp_lin_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic signed [11:0] sample_t;
    typedef logic [11:0]        out_code_t;
    typedef logic [5:0]         limit_code_t;
    typedef logic [23:0]        reg_word_t;
    typedef logic [7:0]         reg_addr_t;

    // Negation saturates, since -2048 has no positive twin
    function automatic sample_t negate_sat(input sample_t v);
        negate_sat = (v == 12'sh800) ? 12'sh7ff : -v;
    endfunction

    // Signed sample to offset-binary output code
    function automatic out_code_t to_code(input sample_t v);
        to_code = {~v[11], v[10:0]};
    endfunction

    // One limit step is 32 output codes, half the scale over 64 steps
    function automatic out_code_t upper_limit(input limit_code_t c);
        upper_limit = `FULL_SCALE_CODE - {1'b0, c, 5'h00};
    endfunction

    function automatic out_code_t lower_limit(input limit_code_t c);
        lower_limit = `ZERO_SCALE_CODE + {1'b0, c, 5'h00};
    endfunction

endpackage

`default_nettype wire

// File: rtl/polarity_stage.sv
// Optional polarity flip of a signed sample.
// Assumes the caller registers the result; this stage is combinational.
`default_nettype none

module polarity_stage
    import clamp_lin_pkg::*;
(
    input  wire sample_t value_i,
    input  wire logic    invert_i,
    input  wire logic    enable_i,
    output sample_t      value_o
);

    // ------------------------------------------------------------------------
    // Flip only while the table path is enabled
    // ------------------------------------------------------------------------
    always_comb begin
        value_o = (enable_i && invert_i) ? negate_sat(value_i) : value_i;
    end

endmodule

`default_nettype wire

// File: rtl/limit_saturate.sv
// Converts a signed sample to an output code and saturates it to the limits.
// Assumes lower limit never crosses upper; the code ranges keep them apart.
`default_nettype none

module limit_saturate
    import clamp_lin_pkg::*;
(
    input  wire sample_t     value_i,
    input  wire limit_code_t upper_code_i,
    input  wire limit_code_t lower_code_i,
    output out_code_t        code_o
);

    out_code_t raw_code;
    out_code_t hi_lim;
    out_code_t lo_lim;

    // ------------------------------------------------------------------------
    // Saturate between the programmed limits
    // ------------------------------------------------------------------------
    always_comb begin
        raw_code = to_code(value_i);
        hi_lim   = upper_limit(upper_code_i);
        lo_lim   = lower_limit(lower_code_i);
        if (raw_code > hi_lim) begin
            code_o = hi_lim;
        end else if (raw_code < lo_lim) begin
            code_o = lo_lim;
        end else begin
            code_o = raw_code;
        end
    end

endmodule

`default_nettype wire

// File: dv/test_output_clamp_lin_polarity.sv
// Self-checking bench of the output clamp and linearizer polarity block.
// Assumes the package and register header in rtl/; the bench acts as the
// register master, the sample source and the external linearizer.
`default_nettype none

module test_output_clamp_lin_polarity
    import clamp_lin_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk_i;
    logic        reset_n_i;
    reg_addr_t   reg_addr_i;
    reg_word_t   reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    reg_word_t   reg_rdata_o;
    sample_t     sample_i;
    logic        sample_valid_i;
    sample_t     lin_feed_o;
    logic        lin_feed_valid_o;
    sample_t     lin_result_i;
    logic        lin_result_valid_i;
    out_code_t   out_code_o;
    logic        out_valid_o;
    int          miscompares;
    int          cmp_count;
    logic [15:0] lfsr_reg;
    reg_word_t   rd_val;

    output_clamp_lin_polarity dut (
        .sys_clk_i          (sys_clk_i),
        .reset_n_i          (reset_n_i),
        .reg_addr_i         (reg_addr_i),
        .reg_wdata_i        (reg_wdata_i),
        .reg_wr_i           (reg_wr_i),
        .reg_rd_i           (reg_rd_i),
        .reg_rdata_o        (reg_rdata_o),
        .sample_i           (sample_i),
        .sample_valid_i     (sample_valid_i),
        .lin_feed_o         (lin_feed_o),
        .lin_feed_valid_o   (lin_feed_valid_o),
        .lin_result_i       (lin_result_i),
        .lin_result_valid_i (lin_result_valid_i),
        .out_code_o         (out_code_o),
        .out_valid_o        (out_valid_o)
    );

    // ------------------------------------------------------------------------
    // Clock, random source and expectation models
    // ------------------------------------------------------------------------
    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Sixteen-bit Fibonacci register; never reaches zero from a nonzero seed
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Saturating negation: the most negative sample has no positive twin
    function automatic sample_t neg_model(input sample_t v);
        neg_model = (v == -12'sd2048) ? 12'sd2047 : -v;
    endfunction

    // Offset-binary code of the sample, squeezed into the limit window
    function automatic out_code_t exp_code(input sample_t v, input logic up_inv,
                                           input limit_code_t up, input limit_code_t lo);
        sample_t w;
        int      c;
        w = up_inv ? neg_model(v) : v;
        c = int'(w) + 2048;
        if (c > 4095 - 32 * int'(up)) c = 4095 - 32 * int'(up);
        if (c < 32 * int'(lo)) c = 32 * int'(lo);
        exp_code = c[11:0];
    endfunction

    // ------------------------------------------------------------------------
    // Checking, verdict and bus tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog so a stuck run still ends in the report
    initial begin
        repeat (50000) @(posedge sys_clk_i);
        miscompares++;
        summarize();
    end

    task automatic reg_write(input reg_addr_t a, input reg_word_t d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, zero after that
    task automatic reg_read_check(input reg_addr_t a, input reg_word_t exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        check(reg_rdata_o, exp);
        @(posedge sys_clk_i);
        #1;
        check(reg_rdata_o, 24'h000000);
    endtask

    task automatic set_cfg(input logic done, input logic post, input logic pre,
                           input limit_code_t up, input limit_code_t lo);
        reg_write(8'h1b, {done, post, pre, lfsr_reg[8:0], 12'h000});
        reg_write(8'h1c, {up, lo, 12'h000});
    endtask

    // One sample through the block; in table mode the bench answers as linearizer
    task automatic run(input sample_t s, input sample_t r, input logic done, input logic post,
                       input logic pre, input limit_code_t up, input limit_code_t lo, input int dly);
        sample_t feed;
        feed = (done && pre) ? neg_model(s) : s;
        @(posedge sys_clk_i);
        sample_i           <= s;
        sample_valid_i     <= 1'b1;
        lin_result_i       <= r;
        lin_result_valid_i <= !done;
        @(posedge sys_clk_i);
        sample_valid_i     <= 1'b0;
        lin_result_valid_i <= 1'b0;
        #1;
        check({12'h000, lin_feed_o}, {12'h000, feed});
        check({23'h0, lin_feed_valid_o}, {23'h0, done});
        check({23'h0, out_valid_o}, 24'h000000);
        if (done) begin
            repeat (dly) @(posedge sys_clk_i);
            @(posedge sys_clk_i);
            lin_result_valid_i <= 1'b1;
            @(posedge sys_clk_i);
            lin_result_valid_i <= 1'b0;
        end else begin
            @(posedge sys_clk_i);
        end
        #1;
        check({23'h0, out_valid_o}, 24'h000001);
        check({12'h000, out_code_o}, {12'h000, exp_code(done ? r : s, done && post, up, lo)});
        @(posedge sys_clk_i);
        #1;
        check({23'h0, out_valid_o}, 24'h000000);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        limit_code_t up;
        limit_code_t lo;
        logic [2:0]  m;
        miscompares = 0;
        cmp_count   = 0;
        lfsr_reg    = 16'h0032;
        reset_n_i   = 1'b0;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 24'h000000;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        sample_i    = 12'sd0;
        sample_valid_i     = 1'b0;
        lin_result_i       = 12'sd0;
        lin_result_valid_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        #1;
        check({12'h000, out_code_o}, 24'h000000);
        // Unprogrammed fields read as zero codes
        reg_read_check(8'h1b, 24'h000000);
        reg_read_check(8'h1c, 24'h000000);
        reg_read_check(8'h1e, 24'h000000);
        // Corner codes: widest window, then both limits at mid-scale
        for (int k = 0; k < 2; k++) begin
            up = k ? 6'h3f : 6'h00;
            lo = k ? 6'h3f : 6'h00;
            set_cfg(1'b0, 1'b1, 1'b1, up, lo);
            run(12'sd2047, 12'sd0, 1'b0, 1'b1, 1'b1, up, lo, 0);
            run(-12'sd2048, 12'sd0, 1'b0, 1'b1, 1'b1, up, lo, 0);
        end
        // One lower step, output inversion at mid-scale, inversion meeting the upper clamp
        set_cfg(1'b0, 1'b0, 1'b0, 6'h00, 6'h01);
        run(-12'sd2048, 12'sd0, 1'b0, 1'b0, 1'b0, 6'h00, 6'h01, 0);
        set_cfg(1'b1, 1'b1, 1'b0, 6'h00, 6'h00);
        run(12'sd5, 12'sd0, 1'b1, 1'b1, 1'b0, 6'h00, 6'h00, 1);
        set_cfg(1'b1, 1'b1, 1'b1, 6'h3f, 6'h00);
        run(12'sd5, -12'sd2048, 1'b1, 1'b1, 1'b1, 6'h3f, 6'h00, 2);
        // Bypass with random limits; stored inversions must not act
        for (int k = 0; k < 24; k++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            up = lfsr_reg[5:0];
            lo = lfsr_reg[11:6];
            set_cfg(1'b0, lfsr_reg[12], lfsr_reg[13], up, lo);
            lfsr_reg = lfsr_next(lfsr_reg);
            run(sample_t'(lfsr_reg[11:0]), 12'sd0, 1'b0, 1'b1, 1'b1, up, lo, 0);
        end
        // Table mode: every pair of inversion settings, both ratiometric modes
        for (int k = 0; k < 8; k++) begin
            m = k[2:0];
            reg_write(8'h1e, {23'h0, m[2]});
            for (int j = 0; j < 6; j++) begin
                lfsr_reg = lfsr_next(lfsr_reg);
                up = lfsr_reg[5:0];
                lo = lfsr_reg[11:6];
                set_cfg(1'b1, m[1], m[0], up, lo);
                lfsr_reg = lfsr_next(lfsr_reg);
                run(j == 0 ? -12'sd2048 : sample_t'(lfsr_reg[11:0]),
                    j == 1 ? -12'sd2048 : sample_t'(lfsr_reg[15:4]),
                    1'b1, m[1], m[0], up, lo, j % 3);
            end
        end
        // Register readback of random words; unused bits and unmapped places read zero
        for (int k = 0; k < 8; k++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            rd_val = {lfsr_reg, lfsr_reg[15:8] ^ lfsr_reg[7:0]};
            reg_write(8'h1b, rd_val);
            reg_write(8'h1c, ~rd_val);
            reg_write(8'h1e, rd_val);
            reg_write(8'h1d, rd_val);
            reg_read_check(8'h1b, rd_val & 24'hfff000);
            reg_read_check(8'h1c, ~rd_val & 24'hfff000);
            reg_read_check(8'h1e, rd_val & 24'h000001);
            reg_read_check(8'h1d, 24'h000000);
        end
        // Reset in mid-run returns limits to the widest window
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        #1;
        check({12'h000, out_code_o}, 24'h000000);
        reg_read_check(8'h1c, 24'h000000);
        summarize();
    end

endmodule

`default_nettype wire
